// *** pkg/sncr_consts.vh ***
// Constants for the switch node configuration register bank.
`ifndef SNCR_CONSTS_VH
`define SNCR_CONSTS_VH
`define SNCR_ADDR_DEVICE_ID 8'h00
`define SNCR_ADDR_SWITCH_DESC 8'h01
`define SNCR_ADDR_SWITCH_CFG 8'h04
`define SNCR_ADDR_NODE_ID 8'h05
`define SNCR_ADDR_PLL 8'h06
`define SNCR_ADDR_SWCLK_DIV 8'h07
`define SNCR_ADDR_REFCLK_DIV 8'h08
`define SNCR_ADDR_JTAG_ID 8'h09
`define SNCR_ADDR_USER_CODE 8'h0a
`define SNCR_ADDR_DIR_LOW 8'h0c
`define SNCR_ADDR_DIR_HIGH 8'h0d
`define SNCR_ADDR_SPARE 8'h10
`define SNCR_CFG_CTRL_LOCK 31
`define SNCR_CFG_PLL_LOCK 8
`define SNCR_CFG_HDR_ONE_BYTE 0
`define SNCR_PLL_NO_RESET 31
`define SNCR_PLL_NO_WAIT 30
`define SNCR_PLL_BYPASS 29
`define SNCR_PLL_BOOT_JTAG 28
`define SNCR_PLL_WRITE_MASK 32'hf39f_ff7f
`define SNCR_PLL_RESET_VALUE 32'h0000_0000
`define SNCR_REFCLK_RESET 16'h0003
`define SNCR_SWCLK_RESET 16'h0000
`define SNCR_TILE_RESET_NS 100
`endif

// *** src/sncr_switch_node_config_regs.v ***
// Configuration register bank and routing decision of the switch node.
// Operation
// - Boot pins captured after reset release in 23:16
// - Revision 15:8, version 7:0, read-only
// - Description reports links and processor counts
// - Config bit 31 locks switch control writes
// - Config bit 8 locks PLL register writes
// - Config bit 0 selects header length
// - Sixteen-bit node identifier, upper bits zero
// - PLL write resets tile unless bit 31
// - PLL bit 31 skips tile reset
// - PLL bit 30 skips relock wait
// - PLL bit 29 bypasses the PLL
// - PLL bit 28 selects JTAG boot
// - Output divider in 25:23, minus one
// - Feedback multiplier in 20:8, minus one
// - Input divider in 6:0, minus one
// - Switch clock divider 15:0, reset zero
// - Reference clock divider 15:0, reset three
// - User code: OTP code and metal ID
// - Low table: directions for bits 0-7
// - Route by highest mismatching identifier bit
// - High table: directions for bits 8-15
// - Links whose direction matches carry packet
`timescale 1ns/100ps
`default_nettype none
`include "sncr_consts.vh"
module sncr_switch_node_config_regs #(
  parameter NUM_LINKS = 8,
  parameter [7:0] SWITCH_REVISION = 8'h01,
  parameter [7:0] SWITCH_VERSION = 8'h01,
  parameter [7:0] PROCS_ON_SWITCH = 8'h02,
  parameter [7:0] PROCS_ON_DEVICE = 8'h02,
  // Arbitrary identity values.
  parameter [31:0] JTAG_ID_CODE = 32'h1234_5001,
  parameter [17:0] METAL_ID_CODE = 18'h00001,
  parameter TILE_RESET_CYCLES = (`SNCR_TILE_RESET_NS * 200 + 999) / 1000
) (
  input wire core_clk,
  input wire reset_n,
  input wire [7:0] boot_select_pins,
  input wire [13:0] otp_user_code,
  input wire cfg_write,
  input wire cfg_read,
  input wire [7:0] cfg_addr,
  input wire [31:0] cfg_wdata,
  output reg [31:0] cfg_rdata,
  output reg cfg_ack,
  input wire [4*NUM_LINKS-1:0] link_direction,
  input wire pkt_valid,
  input wire [15:0] pkt_dest,
  output reg route_valid,
  output reg route_local,
  output reg [3:0] route_direction,
  output reg [NUM_LINKS-1:0] route_links,
  output reg header_one_byte,
  output reg ctrl_write_locked,
  output reg pll_write_locked,
  output reg [31:0] pll_control_register,
  output reg pll_bypass,
  output reg boot_from_jtag,
  output reg pll_skip_relock,
  output reg tile_reset,
  output reg [15:0] switch_clock_divider,
  output reg [15:0] reference_clock_divider
);
  reg [7:0] boot_meta;
  reg [7:0] boot_sync;
  reg [7:0] boot_captured;
  reg boot_taken;
  reg [15:0] node_identifier;
  reg [31:0] direction_table_low;
  reg [31:0] direction_table_high;
  reg [1:0] spare_control;
  reg [15:0] tile_count;
  reg [31:0] next_rdata;
  reg [4:0] hi_bit;
  reg [3:0] next_dir;
  wire [15:0] mismatch;
  wire [63:0] dir_table;
  wire ctrl_wr_ok;
  wire pll_wr;
  reg [NUM_LINKS-1:0] next_links;
  integer i;
  genvar g;
  reg [1:0] boot_wait;
  reg [1:0] tile_state;
  reg [1:0] next_tile_state;
  wire tile_start;
  wire wr_cfg;
  wire wr_node;
  wire wr_swclk;
  wire wr_refclk;
  wire wr_dir_low;
  wire wr_dir_high;
  wire wr_spare;
  wire [31:0] rd_device_id;
  wire [31:0] rd_switch_desc;
  wire [31:0] rd_switch_cfg;
  wire [31:0] rd_node_id;
  wire [31:0] rd_swclk;
  wire [31:0] rd_refclk;
  wire [31:0] rd_user_code;
  wire [31:0] rd_spare;
  wire [15:0] above_clear;
  wire [15:0] top_mismatch;
  localparam TILE_IDLE = 2'b01;
  localparam TILE_HOLD = 2'b10;

  assign mismatch = pkt_dest ^ node_identifier;
  assign dir_table = {direction_table_high, direction_table_low};
  // Locked writes are dropped without any error reply.
  assign ctrl_wr_ok = cfg_write & ~ctrl_write_locked;
  assign pll_wr = cfg_write & (cfg_addr == `SNCR_ADDR_PLL) & ~pll_write_locked;

  // Pins are synchronised, then held once after reset release.
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      boot_meta <= 8'h00;
      boot_sync <= 8'h00;
      boot_captured <= 8'h00;
      boot_taken <= 1'b0;
      boot_wait <= 2'h0;
    end else begin
      boot_meta <= boot_select_pins;
      boot_sync <= boot_meta;
      // Capture waits until the pin level has crossed both synchroniser stages.
      if (!boot_taken) begin
        if (boot_wait == 2'h2) begin
          boot_captured <= boot_sync;
          boot_taken <= 1'b1;
        end else begin
          boot_wait <= boot_wait + 2'h1;
        end
      end
    end
  end

  // One write enable per register; the control lock gates all but 0x04 and 0x06, which has the PLL lock instead.
  assign wr_cfg = cfg_write & (cfg_addr == `SNCR_ADDR_SWITCH_CFG);
  assign wr_node = ctrl_wr_ok & (cfg_addr == `SNCR_ADDR_NODE_ID);
  assign wr_swclk = ctrl_wr_ok & (cfg_addr == `SNCR_ADDR_SWCLK_DIV);
  assign wr_refclk = ctrl_wr_ok & (cfg_addr == `SNCR_ADDR_REFCLK_DIV);
  assign wr_dir_low = ctrl_wr_ok & (cfg_addr == `SNCR_ADDR_DIR_LOW);
  assign wr_dir_high = ctrl_wr_ok & (cfg_addr == `SNCR_ADDR_DIR_HIGH);
  assign wr_spare = ctrl_wr_ok & (cfg_addr == `SNCR_ADDR_SPARE);

  // The configuration bits are never themselves locked, so a lock can be lifted.
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_write_locked <= 1'b0;
      pll_write_locked <= 1'b0;
      header_one_byte <= 1'b0;
    end else if (wr_cfg) begin
      ctrl_write_locked <= cfg_wdata[`SNCR_CFG_CTRL_LOCK];
      pll_write_locked <= cfg_wdata[`SNCR_CFG_PLL_LOCK];
      header_one_byte <= cfg_wdata[`SNCR_CFG_HDR_ONE_BYTE];
    end
  end

  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      node_identifier <= 16'h0000;
    end else if (wr_node) begin
      node_identifier <= cfg_wdata[15:0];
    end
  end

  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      switch_clock_divider <= `SNCR_SWCLK_RESET;
    end else if (wr_swclk) begin
      switch_clock_divider <= cfg_wdata[15:0];
    end
  end

  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      reference_clock_divider <= `SNCR_REFCLK_RESET;
    end else if (wr_refclk) begin
      reference_clock_divider <= cfg_wdata[15:0];
    end
  end

  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      direction_table_low <= 32'h0000_0000;
    end else if (wr_dir_low) begin
      direction_table_low <= cfg_wdata;
    end
  end

  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      direction_table_high <= 32'h0000_0000;
    end else if (wr_dir_high) begin
      direction_table_high <= cfg_wdata;
    end
  end

  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      spare_control <= 2'h0;
    end else if (wr_spare) begin
      spare_control <= cfg_wdata[1:0];
    end
  end

  assign tile_start = pll_wr & ~cfg_wdata[`SNCR_PLL_NO_RESET];

  // Fields keep their minus-one codes; reserved bits are masked off.
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pll_control_register <= `SNCR_PLL_RESET_VALUE;
    end else if (pll_wr) begin
      pll_control_register <= cfg_wdata & `SNCR_PLL_WRITE_MASK;
    end
  end

  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pll_bypass <= 1'b0;
      boot_from_jtag <= 1'b0;
      pll_skip_relock <= 1'b0;
    end else if (pll_wr) begin
      pll_bypass <= cfg_wdata[`SNCR_PLL_BYPASS];
      boot_from_jtag <= cfg_wdata[`SNCR_PLL_BOOT_JTAG];
      pll_skip_relock <= cfg_wdata[`SNCR_PLL_NO_WAIT];
    end
  end

  // A new accepted write restarts the hold, so the pulse never ends early.
  always @* begin
    next_tile_state = tile_state;
    case (tile_state)
      TILE_IDLE: begin
        if (tile_start) begin
          next_tile_state = TILE_HOLD;
        end
      end
      TILE_HOLD: begin
        if (!tile_start && tile_count <= 16'h0001) begin
          next_tile_state = TILE_IDLE;
        end
      end
      default: begin
        next_tile_state = TILE_IDLE;
      end
    endcase
  end

  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      tile_state <= TILE_IDLE;
      tile_reset <= 1'b0;
      tile_count <= 16'h0000;
    end else begin
      tile_state <= next_tile_state;
      tile_reset <= next_tile_state[1];
      if (tile_start) begin
        tile_count <= TILE_RESET_CYCLES[15:0];
      end else if (tile_count > 16'h0001) begin
        tile_count <= tile_count - 16'h0001;
      end else begin
        tile_count <= 16'h0000;
      end
    end
  end

  // Read words are assembled here; reserved fields always read as zero.
  assign rd_device_id = {8'h00, boot_captured, SWITCH_REVISION, SWITCH_VERSION};
  assign rd_switch_desc = {8'h00, NUM_LINKS[7:0], PROCS_ON_SWITCH, PROCS_ON_DEVICE};
  assign rd_switch_cfg = {ctrl_write_locked, 22'h000000, pll_write_locked, 7'h00,
    header_one_byte};
  assign rd_node_id = {16'h0000, node_identifier};
  assign rd_swclk = {16'h0000, switch_clock_divider};
  assign rd_refclk = {16'h0000, reference_clock_divider};
  assign rd_user_code = {otp_user_code, METAL_ID_CODE};
  assign rd_spare = {30'h00000000, spare_control};

  always @* begin
    case (cfg_addr)
      `SNCR_ADDR_DEVICE_ID: next_rdata = rd_device_id;
      `SNCR_ADDR_SWITCH_DESC: next_rdata = rd_switch_desc;
      `SNCR_ADDR_SWITCH_CFG: next_rdata = rd_switch_cfg;
      `SNCR_ADDR_NODE_ID: next_rdata = rd_node_id;
      `SNCR_ADDR_PLL: next_rdata = pll_control_register;
      `SNCR_ADDR_SWCLK_DIV: next_rdata = rd_swclk;
      `SNCR_ADDR_REFCLK_DIV: next_rdata = rd_refclk;
      `SNCR_ADDR_JTAG_ID: next_rdata = JTAG_ID_CODE;
      `SNCR_ADDR_USER_CODE: next_rdata = rd_user_code;
      `SNCR_ADDR_DIR_LOW: next_rdata = direction_table_low;
      `SNCR_ADDR_DIR_HIGH: next_rdata = direction_table_high;
      `SNCR_ADDR_SPARE: next_rdata = rd_spare;
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cfg_rdata <= 32'h0000_0000;
      cfg_ack <= 1'b0;
    end else begin
      cfg_ack <= cfg_read | cfg_write;
      if (cfg_read) begin
        cfg_rdata <= next_rdata;
      end
    end
  end

  // Each bit knows whether all higher bits agree, giving a one-hot top mismatch.
  generate
    for (g = 0; g < 16; g = g + 1) begin : hi_scan
      if (g == 15) begin : top
        assign above_clear[g] = 1'b1;
      end else begin : rest
        assign above_clear[g] = ~|mismatch[15:g+1];
      end
      assign top_mismatch[g] = mismatch[g] & above_clear[g];
    end
  endgenerate

  // The one-hot top mismatch is encoded into a table index.
  always @* begin
    hi_bit = 5'h00;
    for (i = 0; i < 16; i = i + 1) begin
      if (top_mismatch[i]) begin
        hi_bit = i[4:0];
      end
    end
    next_dir = dir_table[{hi_bit[3:0], 2'b00} +: 4];
  end

  generate
    for (g = 0; g < NUM_LINKS; g = g + 1) begin : link_match
      always @* begin
        next_links[g] = (link_direction[4*g +: 4] == next_dir);
      end
    end
  endgenerate

  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      route_valid <= 1'b0;
      route_local <= 1'b0;
      route_direction <= 4'h0;
      route_links <= {NUM_LINKS{1'b0}};
    end else begin
      route_valid <= pkt_valid;
      route_local <= pkt_valid & (mismatch == 16'h0000);
      route_direction <= (mismatch == 16'h0000) ? 4'h0 : next_dir;
      route_links <= (pkt_valid && mismatch != 16'h0000) ? next_links
        : {NUM_LINKS{1'b0}};
    end
  end
endmodule // sncr_switch_node_config_regs
`default_nettype wire

// *** bench/sncr_props.sv ***
// Assertion checker for the switch node configuration bank.
`timescale 1ns/100ps
`default_nettype none
module sncr_props #(
  parameter TILE_RESET_CYCLES = 20
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic cfg_write,
  input wire logic cfg_read,
  input wire logic [7:0] cfg_addr,
  input wire logic [31:0] cfg_wdata,
  input wire logic cfg_ack,
  input wire logic pkt_valid,
  input wire logic route_valid,
  input wire logic header_one_byte,
  input wire logic ctrl_write_locked,
  input wire logic pll_write_locked,
  input wire logic pll_bypass,
  input wire logic tile_reset,
  input wire logic [15:0] reference_clock_divider
);
  logic [7:0] high_cnt;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  // A counter keeps the pulse length check free of long repetitions.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) high_cnt <= 8'h00;
    else high_cnt <= tile_reset ? high_cnt + 8'h01 : 8'h00;
  end
  sequence s_pll_go;
    cfg_write && cfg_addr == 8'h06 && !pll_write_locked;
  endsequence
  a_ack_after_req: assert property ((cfg_write || cfg_read) |=> cfg_ack)
    else $error("no acknowledge");
  a_route_one_cycle: assert property (pkt_valid |=> route_valid)
    else $error("no route result");
  a_cfg_bits_load: assert property (cfg_write && cfg_addr == 8'h04 |=> ctrl_write_locked ==
    $past(cfg_wdata[31]) && pll_write_locked == $past(cfg_wdata[8]) && header_one_byte == $past(cfg_wdata[0])) else $error("config bits");
  a_pll_bypass_load: assert property (s_pll_go |=> pll_bypass == $past(cfg_wdata[29]))
    else $error("bypass bit");
  a_refclk_locked: assert property (cfg_write && cfg_addr == 8'h08 && ctrl_write_locked |=> $stable(reference_clock_divider))
    else $error("locked divider changed");
  a_tile_reset_start: assert property (s_pll_go ##0 !cfg_wdata[31] |-> ##[1:2] tile_reset)
    else $error("no tile reset");
  a_tile_reset_quiet: assert property (s_pll_go ##0 cfg_wdata[31] && !tile_reset |=> !tile_reset)
    else $error("tile reset not skipped");
  a_tile_reset_len: assert property ($fell(tile_reset) |-> high_cnt == TILE_RESET_CYCLES)
    else $error("tile reset length");
endmodule // sncr_props
bind sncr_switch_node_config_regs sncr_props #(.TILE_RESET_CYCLES(TILE_RESET_CYCLES)) u_props (.*);
`default_nettype wire

// *** bench/testbench.sv ***
// Self-checking bench for the switch node configuration bank.
`timescale 1ns/100ps
`default_nettype none
`include "sncr_consts.vh"
module testbench;
  logic core_clk = 1'b0, reset_n = 1'b0, cfg_write = 1'b0, cfg_read = 1'b0, pkt_valid = 1'b0;
  logic [7:0] boot_select_pins = 8'ha5, cfg_addr = 8'h00, route_links, lk;
  logic [13:0] otp_user_code = 14'h0000;
  logic [31:0] cfg_rdata, pll_control_register, seed = 32'h5bd5, d, cfg_wdata = 32'h0;
  logic [31:0] link_direction = 32'h0;
  logic [15:0] switch_clock_divider, reference_clock_divider, nid, pkt_dest = 16'h0;
  logic [3:0] route_direction;
  logic cfg_ack, route_valid, route_local, header_one_byte, ctrl_write_locked, pll_write_locked;
  logic pll_bypass, boot_from_jtag, pll_skip_relock, tile_reset;
  logic [63:0] note, tbl, notes[$];
  logic [31:0] rnotes[$], wv[6];
  logic [7:0] wa[6] = '{8'h05, 8'h07, 8'h08, 8'h0c, 8'h0d, 8'h10};
  logic [31:0] wm[6] = '{32'hffff, 32'hffff, 32'hffff, '1, '1, 32'h3};
  int num_errors = 0, n_compared = 0;
  sncr_switch_node_config_regs #(.TILE_RESET_CYCLES(2)) dut_u (.*);
  always #2.5 core_clk = ~core_clk;
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic chk(input string what, input logic [31:0] exp, got);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // A zero mask marks a write, whose acknowledge carries no data.
  task automatic req(input logic wr, input logic [7:0] a, input logic [31:0] dat, m, e);
    @(negedge core_clk);
    cfg_write = wr;
    cfg_read = !wr;
    cfg_addr = a;
    cfg_wdata = dat;
    notes.push_back({m, e});
    @(negedge core_clk);
    cfg_write = 1'b0;
    cfg_read = 1'b0;
  endtask
  task automatic route(input logic [15:0] dst, input logic [31:0] e);
    @(negedge core_clk);
    pkt_valid = 1'b1;
    pkt_dest = dst;
    rnotes.push_back(e);
    @(negedge core_clk);
    pkt_valid = 1'b0;
  endtask
  always @(negedge core_clk) begin
    if (cfg_ack === 1'b1 && notes.size() > 0) begin
      note = notes.pop_front();
      if (note[63:32] != 32'h0) chk("cfg_rdata", note[31:0], cfg_rdata & note[63:32]);
    end
    if (route_valid === 1'b1 && rnotes.size() > 0)
      chk("route", rnotes.pop_front(), {19'h0, route_local, route_direction, route_links});
  end
  task automatic wrap_up;
    $display("Compared %0d, errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    #20000;
    num_errors++;
    wrap_up;
  end
  initial begin
    otp_user_code = seed[13:0];
    seed = lfsr(seed);
    link_direction = seed;
    repeat (3) @(negedge core_clk);
    reset_n = 1'b1;
    repeat (3) @(negedge core_clk);
    chk("refclk", 32'h3, {16'h0, reference_clock_divider});
    foreach (wa[i]) req(1'b0, wa[i], 32'h0, '1, wa[i] == 8'h08 ? 32'h3 : 32'h0);
    req(1'b0, 8'h04, 32'h0, '1, 32'h0);
    req(1'b0, 8'h02, 32'h0, '1, 32'h0);
    for (int i = 0; i < 2; i++) begin
      req(1'b0, 8'h00, 32'h0, '1, 32'h00a5_0101);
      req(1'b0, 8'h01, 32'h0, '1, 32'h0008_0202);
      req(1'b0, 8'h0a, 32'h0, '1, {otp_user_code, 18'h1});
      req(1'b1, 8'h00, '1, 32'h0, 32'h0);
      req(1'b1, 8'h01, '1, 32'h0, 32'h0);
      req(1'b1, 8'h0a, '1, 32'h0, 32'h0);
    end
    foreach (wa[i]) begin
      seed = lfsr(seed);
      wv[i] = seed & wm[i];
      req(1'b1, wa[i], seed, 32'h0, 32'h0);
      req(1'b0, wa[i], 32'h0, '1, wv[i]);
    end
    chk("swclk", wv[1], {16'h0, switch_clock_divider});
    nid = wv[0][15:0];
    tbl = {wv[4], wv[3]};
    for (int k = 0; k < 16; k++) begin
      seed = lfsr(seed);
      for (int j = 0; j < 8; j++) lk[j] = link_direction[4*j +: 4] == tbl[4*k +: 4];
      route(nid ^ (16'h1 << k) ^ (seed[15:0] & ((16'h1 << k) - 16'h1)), {tbl[4*k +: 4], lk});
    end
    route(nid, 32'h1000);
    req(1'b1, 8'h04, '1, 32'h0, 32'h0);
    req(1'b0, 8'h04, 32'h0, '1, 32'h8000_0101);
    chk("hdr", 32'h1, {31'h0, header_one_byte});
    foreach (wa[i]) begin
      req(1'b1, wa[i], ~wv[i], 32'h0, 32'h0);
      req(1'b0, wa[i], 32'h0, '1, wv[i]);
    end
    req(1'b1, 8'h06, 32'h1, 32'h0, 32'h0);
    req(1'b0, 8'h06, 32'h0, '1, 32'h0);
    req(1'b1, 8'h04, 32'h0, 32'h0, 32'h0);
    req(1'b1, 8'h06, '1, 32'h0, 32'h0);
    chk("tile_quiet", 32'h0, {31'h0, tile_reset});
    chk("pll_flags", 32'h7, {29'h0, pll_bypass, boot_from_jtag, pll_skip_relock});
    req(1'b0, 8'h06, 32'h0, '1, `SNCR_PLL_WRITE_MASK);
    seed = lfsr(seed);
    d = seed & 32'h7fff_ffff;
    req(1'b1, 8'h06, d, 32'h0, 32'h0);
    chk("tile_reset", 32'h1, {31'h0, tile_reset});
    chk("pll_reg", d & `SNCR_PLL_WRITE_MASK, pll_control_register);
    chk("pll_flags", {29'h0, d[29], d[28], d[30]}, {29'h0, pll_bypass, boot_from_jtag, pll_skip_relock});
    req(1'b0, 8'h06, 32'h0, '1, d & `SNCR_PLL_WRITE_MASK);
    repeat (6) @(negedge core_clk);
    chk("pending", 32'h0, notes.size() + rnotes.size());
    wrap_up;
  end
endmodule // testbench
`default_nettype wire
